/* anp_autoneg.sv */
`timescale 1ns/1ps
module anp_autoneg #(
    parameter int unsigned BREAK_CYC = anp_pkg::BREAK_LINK_CYC,
    parameter int unsigned WAIT_CYC = anp_pkg::NEG_WAIT_CYC,
    parameter int unsigned INHIBIT_CYC = anp_pkg::LINK_INHIBIT_CYC,
    parameter int unsigned EXCHANGE_CYC = anp_pkg::FLP_EXCHANGE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [4:0] mgmt_addr_i,
    input wire logic mgmt_wr_i,
    input wire logic [15:0] mgmt_wdata_i,
    input wire logic mgmt_rd_i,
    output logic [15:0] mgmt_rdata_o,
    input wire logic link_10_i,
    input wire logic link_100_i,
    input wire logic page_rx_i,
    input wire logic [15:0] page_word_i,
    output logic [15:0] adv_word_o,
    output logic flp_enable_o,
    output logic tx_suppress_o,
    output logic neg_complete_o,
    output logic speed_100_o,
    output logic full_duplex_o,
    output logic link_ok_o
);
    typedef struct packed {
        anp_pkg::anp_state_e st;
        logic [15:0] ctl;
        logic [15:0] adv;
        logic [15:0] lp;
        logic multi_fault;
        logic page_rcvd;
        logic partner_able;
        logic res_100;
        logic res_fd;
        logic [anp_pkg::TIMER_W-1:0] timer;
        logic l10_s1;
        logic l10_s2;
        logic l100_s1;
        logic l100_s2;
        logic [15:0] rdata;
    } anp_regs_s;

    // Cycle counts cut to the timer width on purpose
    localparam int TW = anp_pkg::TIMER_W;
    localparam logic [TW-1:0] BREAK_LAST =
        TW'(BREAK_CYC - 1);
    localparam logic [TW-1:0] WAIT_LAST =
        TW'(WAIT_CYC - 1);
    localparam logic [TW-1:0] INHIBIT_LAST =
        TW'(INHIBIT_CYC - 1);
    localparam logic [TW-1:0] EXCHANGE_LAST =
        TW'(EXCHANGE_CYC - 1);

    localparam anp_regs_s REGS_RESET = '{
        st: anp_pkg::ST_FORCED,
        ctl: anp_pkg::CTL_RESET,
        adv: anp_pkg::ADV_RESET,
        lp: 16'h0000,
        multi_fault: 1'b0,
        page_rcvd: 1'b0,
        partner_able: 1'b0,
        res_100: 1'b0,
        res_fd: 1'b0,
        timer: '0,
        l10_s1: 1'b0,
        l10_s2: 1'b0,
        l100_s1: 1'b0,
        l100_s2: 1'b0,
        rdata: 16'h0000
    };

    anp_regs_s r;
    anp_regs_s next_r;

    // Link of whichever speed is in use
    function automatic logic link_of(input logic is_100, input logic l10,
                                     input logic l100);
        link_of = is_100 ? l100 : l10;
    endfunction

    // One strobe aimed at one register index
    function automatic logic reg_hit(input logic strobe,
                                     input logic [4:0] addr,
                                     input logic [4:0] target);
        reg_hit = strobe && (addr == target);
    endfunction

    // Highest shared ability wins: 100 FD, 100 HD, 10 FD, 10 HD
    function automatic logic [1:0] resolve(input logic [3:0] both);
        resolve[1] = both[3] || both[2];
        resolve[0] = both[3] || (!both[2] && both[1]);
    endfunction

    logic link_now;
    logic complete;
    logic neg_en;
    logic [15:0] status_word;
    logic [15:0] exp_word;
    logic [3:0] common;
    logic [1:0] best;
    logic soft_reset;

    assign neg_en = r.ctl[anp_pkg::CTL_NEG_ENABLE];
    assign complete = (r.st == anp_pkg::ST_GOOD);
    assign link_now = neg_en ? (complete &&
                                link_of(r.res_100, r.l10_s2, r.l100_s2))
                             : link_of(r.ctl[anp_pkg::CTL_SPEED_100],
                                       r.l10_s2, r.l100_s2);

    always_comb begin
        status_word = anp_pkg::STATUS_FIXED;
        status_word[anp_pkg::STS_COMPLETE] = complete;
        status_word[anp_pkg::STS_REMOTE_FAULT] =
            r.lp[anp_pkg::ABL_REMOTE_FAULT];
        status_word[anp_pkg::STS_LINK] = link_now;
    end

    always_comb begin
        exp_word = 16'h0000;
        exp_word[anp_pkg::EXP_MULTI_FAULT] = r.multi_fault;
        exp_word[anp_pkg::EXP_PARTNER_NP] = r.lp[anp_pkg::ABL_NEXT_PAGE];
        exp_word[anp_pkg::EXP_LOCAL_NP] = 1'b0;
        exp_word[anp_pkg::EXP_PAGE_RCVD] = r.page_rcvd;
        exp_word[anp_pkg::EXP_PARTNER_ABLE] = r.partner_able;
    end

    // Abilities shared by both ends, 100 FD down to 10 HD
    assign common = r.adv[anp_pkg::ABL_100_FD:anp_pkg::ABL_10_HD] &
                    r.lp[anp_pkg::ABL_100_FD:anp_pkg::ABL_10_HD];
    assign best = resolve(common);
    assign soft_reset = reg_hit(mgmt_wr_i, mgmt_addr_i,
                                anp_pkg::ADDR_BASIC_CONTROL) &&
                        mgmt_wdata_i[anp_pkg::CTL_SOFT_RESET];

    always_comb begin
        logic pd_10;
        logic pd_100;
        logic rd_exp;
        logic restart_go;
        next_r = r;
        pd_10 = 1'b0;
        pd_100 = 1'b0;
        rd_exp = reg_hit(mgmt_rd_i, mgmt_addr_i, anp_pkg::ADDR_EXPANSION);
        restart_go = 1'b0;

        // Link inputs come from the analog receivers, asynchronous
        next_r.l10_s1 = link_10_i;
        next_r.l10_s2 = r.l10_s1;
        next_r.l100_s1 = link_100_i;
        next_r.l100_s2 = r.l100_s1;

        // Qualified detection: only speeds advertised as half duplex count
        pd_10 = r.l10_s2 && r.adv[anp_pkg::ABL_10_HD];
        pd_100 = r.l100_s2 && r.adv[anp_pkg::ABL_100_HD];

        // Read-clear flags; a set later in this pass still wins
        if (rd_exp) begin
            next_r.multi_fault = 1'b0;
            next_r.page_rcvd = 1'b0;
        end

        next_r.ctl[anp_pkg::CTL_RESTART] = 1'b0;
        if (mgmt_wr_i) begin
            case (mgmt_addr_i)
                anp_pkg::ADDR_BASIC_CONTROL: begin
                    next_r.ctl = mgmt_wdata_i & anp_pkg::CTL_STORED_MASK;
                    next_r.ctl[anp_pkg::CTL_RESTART] =
                        mgmt_wdata_i[anp_pkg::CTL_RESTART];
                end
                anp_pkg::ADDR_ADVERTISED: begin
                    next_r.adv = (mgmt_wdata_i & anp_pkg::ADV_WRITE_MASK) |
                                 (anp_pkg::ADV_RESET &
                                  ~anp_pkg::ADV_WRITE_MASK);
                end
                default: begin
                end
            endcase
        end

        if (page_rx_i) begin
            next_r.lp = page_word_i;
            next_r.page_rcvd = 1'b1;
            next_r.partner_able = 1'b1;
        end

        case (r.st)
            anp_pkg::ST_FORCED: begin
                // Any set enable, the reset default included, starts negotiation from forced
                if (next_r.ctl[anp_pkg::CTL_NEG_ENABLE]) begin
                    next_r.st = anp_pkg::ST_BREAK;
                end
            end
            anp_pkg::ST_BREAK: begin
                if (r.timer == BREAK_LAST) begin
                    next_r.st = anp_pkg::ST_ABILITY;
                end
            end
            anp_pkg::ST_ABILITY: begin
                if (page_rx_i) begin
                    next_r.st = anp_pkg::ST_EXCHANGE;
                end else if (r.l10_s2 && r.l100_s2) begin
                    next_r.multi_fault = 1'b1;
                end else if (pd_10 || pd_100) begin
                    next_r.st = anp_pkg::ST_PD_WAIT;
                end
            end
            anp_pkg::ST_EXCHANGE: begin
                if (r.timer == EXCHANGE_LAST) begin
                    // No shared ability: back to ability detect instead of inhibit
                    if (common != 4'h0) begin
                        next_r.st = anp_pkg::ST_INHIBIT;
                        next_r.res_100 = best[1];
                        next_r.res_fd = best[0];
                    end else begin
                        next_r.st = anp_pkg::ST_ABILITY;
                    end
                end
            end
            anp_pkg::ST_PD_WAIT: begin
                // A lone detected speed must hold for the whole wait
                if (r.l10_s2 && r.l100_s2) begin
                    next_r.multi_fault = 1'b1;
                    next_r.st = anp_pkg::ST_ABILITY;
                end else if (!(pd_10 || pd_100)) begin
                    next_r.st = anp_pkg::ST_ABILITY;
                end else if (r.timer == WAIT_LAST) begin
                    next_r.st = anp_pkg::ST_INHIBIT;
                    next_r.res_100 = pd_100;
                    next_r.res_fd = 1'b0;
                    next_r.lp = 16'h0000;
                    next_r.lp[anp_pkg::ABL_100_HD] = pd_100;
                    next_r.lp[anp_pkg::ABL_10_HD] = pd_10;
                    next_r.partner_able = 1'b0;
                end
            end
            anp_pkg::ST_INHIBIT: begin
                // Chosen speed must show link before inhibit runs out
                if (link_of(r.res_100, r.l10_s2, r.l100_s2)) begin
                    next_r.st = anp_pkg::ST_GOOD;
                end else if (r.timer == INHIBIT_LAST) begin
                    next_r.st = anp_pkg::ST_BREAK;
                end
            end
            anp_pkg::ST_GOOD: begin
                // Cable pulled: negotiate again from break link
                if (!link_of(r.res_100, r.l10_s2, r.l100_s2)) begin
                    next_r.st = anp_pkg::ST_BREAK;
                end
            end
            default: begin
                next_r.st = anp_pkg::ST_FORCED;
            end
        endcase

        // Restart from any negotiating state goes through break link
        if (next_r.ctl[anp_pkg::CTL_RESTART] && neg_en &&
            r.st != anp_pkg::ST_FORCED) begin
            next_r.st = anp_pkg::ST_BREAK;
            restart_go = 1'b1;
        end
        if (!next_r.ctl[anp_pkg::CTL_NEG_ENABLE]) begin
            next_r.st = anp_pkg::ST_FORCED;
        end

        // Every phase starts its timer afresh; a restart inside break
        // link starts the whole silence over
        if (next_r.st != r.st || restart_go) begin
            next_r.timer = '0;
        end else begin
            next_r.timer = r.timer + 1'b1;
        end

        // Read data is registered and holds until the next read or a soft reset
        next_r.rdata = r.rdata;
        if (mgmt_rd_i) begin
            case (mgmt_addr_i)
                anp_pkg::ADDR_BASIC_CONTROL: next_r.rdata = r.ctl;
                anp_pkg::ADDR_BASIC_STATUS: next_r.rdata = status_word;
                anp_pkg::ADDR_ADVERTISED: next_r.rdata = r.adv;
                anp_pkg::ADDR_PARTNER: next_r.rdata = r.lp;
                anp_pkg::ADDR_EXPANSION: next_r.rdata = exp_word;
                default: next_r.rdata = 16'h0000;
            endcase
        end

        // Software reset returns all but the link synchronizers to defaults next cycle
        if (soft_reset) begin
            next_r = REGS_RESET;
            next_r.l10_s1 = r.l10_s1;
            next_r.l10_s2 = r.l10_s2;
            next_r.l100_s1 = r.l100_s1;
            next_r.l100_s2 = r.l100_s2;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= REGS_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign mgmt_rdata_o = r.rdata;
    assign adv_word_o = r.adv;
    // Bursts go out while abilities are offered and exchanged
    assign flp_enable_o = (r.st == anp_pkg::ST_ABILITY) ||
                          (r.st == anp_pkg::ST_EXCHANGE);
    assign tx_suppress_o = (r.st == anp_pkg::ST_BREAK);
    assign neg_complete_o = complete;
    // Forced mode uses control bits; negotiation uses the result
    assign speed_100_o = neg_en ? r.res_100
                                : r.ctl[anp_pkg::CTL_SPEED_100];
    assign full_duplex_o = neg_en ? r.res_fd
                                  : r.ctl[anp_pkg::CTL_FULL_DUPLEX];
    assign link_ok_o = link_now;
endmodule

/* anp_pkg.sv */
package anp_pkg;
    // Register indices on the management port
    localparam logic [4:0] ADDR_BASIC_CONTROL = 5'h00;
    localparam logic [4:0] ADDR_BASIC_STATUS = 5'h01;
    localparam logic [4:0] ADDR_ADVERTISED = 5'h04;
    localparam logic [4:0] ADDR_PARTNER = 5'h05;
    localparam logic [4:0] ADDR_EXPANSION = 5'h06;

    // Basic control field positions
    localparam int CTL_SOFT_RESET = 15;
    localparam int CTL_LOOPBACK = 14;
    localparam int CTL_SPEED_100 = 13;
    localparam int CTL_NEG_ENABLE = 12;
    localparam int CTL_POWER_DOWN = 11;
    localparam int CTL_ISOLATE = 10;
    localparam int CTL_RESTART = 9;
    localparam int CTL_FULL_DUPLEX = 8;
    localparam int CTL_COLL_TEST = 7;
    localparam logic [15:0] CTL_RESET = 16'h3000;
    localparam logic [15:0] CTL_STORED_MASK = 16'h7D80;

    // Basic status: fixed abilities, T4 clear, preamble suppression
    localparam logic [15:0] STATUS_FIXED = 16'h7849;
    localparam int STS_COMPLETE = 5;
    localparam int STS_REMOTE_FAULT = 4;
    localparam int STS_LINK = 2;

    // Ability word layout
    localparam int ABL_NEXT_PAGE = 15;
    localparam int ABL_REMOTE_FAULT = 13;
    localparam int ABL_100_FD = 8;
    localparam int ABL_100_HD = 7;
    localparam int ABL_10_FD = 6;
    localparam int ABL_10_HD = 5;
    localparam logic [15:0] ADV_RESET = 16'h01E1;
    localparam logic [15:0] ADV_WRITE_MASK = 16'h21E0;

    // Expansion field positions
    localparam int EXP_MULTI_FAULT = 4;
    localparam int EXP_PARTNER_NP = 3;
    localparam int EXP_LOCAL_NP = 2;
    localparam int EXP_PAGE_RCVD = 1;
    localparam int EXP_PARTNER_ABLE = 0;

    // Timing: clock in kHz times milliseconds gives cycles
    localparam int unsigned CLK_KHZ = 100_000;
    localparam int unsigned BREAK_LINK_MS = 1300;
    localparam int unsigned NEG_WAIT_MS = 750;
    localparam int unsigned LINK_INHIBIT_MS = 800;
    localparam int unsigned FLP_EXCHANGE_MS = 200;
    localparam int unsigned BREAK_LINK_CYC = BREAK_LINK_MS * CLK_KHZ;
    localparam int unsigned NEG_WAIT_CYC = NEG_WAIT_MS * CLK_KHZ;
    localparam int unsigned LINK_INHIBIT_CYC = LINK_INHIBIT_MS * CLK_KHZ;
    localparam int unsigned FLP_EXCHANGE_CYC = FLP_EXCHANGE_MS * CLK_KHZ;
    localparam int TIMER_W = 28;

    typedef enum logic [2:0] {
        ST_FORCED,
        ST_BREAK,
        ST_ABILITY,
        ST_EXCHANGE,
        ST_PD_WAIT,
        ST_INHIBIT,
        ST_GOOD
    } anp_state_e;
endpackage

/* anp_autoneg_checker.sv */
`timescale 1ns/1ps
module anp_autoneg_checker #(
    parameter int unsigned BREAK_CYC = 20
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [4:0] mgmt_addr_i,
    input wire logic mgmt_wr_i,
    input wire logic [15:0] mgmt_wdata_i,
    input wire logic mgmt_rd_i,
    input wire logic [15:0] mgmt_rdata_o,
    input wire logic [15:0] adv_word_o,
    input wire logic flp_enable_o,
    input wire logic tx_suppress_o,
    input wire logic neg_complete_o,
    input wire logic speed_100_o,
    input wire logic full_duplex_o,
    input wire logic link_ok_o
);
    logic [31:0] brk_cnt;
    logic [31:0] next_brk_cnt;
    logic rd_st;
    logic rd_ex;
    logic wr_ct;
    assign rd_st = mgmt_rd_i && mgmt_addr_i == 5'h01;
    assign rd_ex = mgmt_rd_i && mgmt_addr_i == 5'h06;
    assign wr_ct = mgmt_wr_i && mgmt_addr_i == 5'h00 && !mgmt_wdata_i[15];
    // Consecutive silent cycles, so the break length is seen exactly
    // A restart request starts the silence over
    always_comb begin
        if (wr_ct && mgmt_wdata_i[12] && mgmt_wdata_i[9]) begin
            next_brk_cnt = '0;
        end else begin
            next_brk_cnt = tx_suppress_o ? brk_cnt + 32'h0000_0001 : '0;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            brk_cnt <= '0;
        end else begin
            brk_cnt <= next_brk_cnt;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_status_fixed: assert property (rd_st |=>
        (mgmt_rdata_o & 16'hF849) == 16'h7849) else $error("fixed bits");
    a_status_done: assert property (rd_st |=>
        mgmt_rdata_o[5] == $past(neg_complete_o)) else $error("done bit");
    a_status_link: assert property (rd_st |=>
        mgmt_rdata_o[2] == $past(link_ok_o)) else $error("link bit");
    a_exp_local_np: assert property (rd_ex |=> !mgmt_rdata_o[2])
        else $error("local next page set");
    a_quiet_break: assert property (tx_suppress_o |->
        !flp_enable_o && !neg_complete_o) else $error("noisy break");
    a_break_len: assert property ($fell(tx_suppress_o) && flp_enable_o
        |-> brk_cnt == BREAK_CYC) else $error("break length");
    a_adv_write: assert property (mgmt_wr_i && mgmt_addr_i == 5'h04 |=>
        adv_word_o == (($past(mgmt_wdata_i) & 16'h21E0) | 16'h0001))
        else $error("advertisement write");
    a_restart_go: assert property (wr_ct && mgmt_wdata_i[12] &&
        mgmt_wdata_i[9] |=> tx_suppress_o) else $error("restart");
    a_forced_mode: assert property (wr_ct && !mgmt_wdata_i[12] |=>
        !flp_enable_o && !tx_suppress_o &&
        speed_100_o == $past(mgmt_wdata_i[13]) &&
        full_duplex_o == $past(mgmt_wdata_i[8])) else $error("forced");
    c_done: cover property ($rose(neg_complete_o));
    c_forced: cover property (wr_ct && !mgmt_wdata_i[12]);
    c_exp_read: cover property (rd_ex ##1 mgmt_rdata_o[4]);
endmodule

/* anp_link_partner.sv */
`timescale 1ns/1ps
module anp_link_partner (
    input wire logic clk_i,
    input wire logic want_10_i,
    input wire logic want_100_i,
    input wire logic page_go_i,
    input wire logic [15:0] page_val_i,
    output logic link_10_o,
    output logic link_100_o,
    output logic page_rx_o,
    output logic [15:0] page_word_o
);
    initial begin
        link_10_o = 1'b0;
        link_100_o = 1'b0;
        page_rx_o = 1'b0;
        page_word_o = 16'h0000;
    end
    // Word is only meaningful with the pulse; otherwise it churns
    always @(negedge clk_i) begin
        link_10_o <= want_10_i;
        link_100_o <= want_100_i;
        page_rx_o <= page_go_i;
        page_word_o <= page_go_i ? page_val_i : ~page_word_o;
    end
endmodule

/* anp_autoneg_tb.sv */
`timescale 1ns/1ps
module anp_autoneg_tb;
    logic clk_i, rst_i, mgmt_wr_i, mgmt_rd_i, w10, w100, pgo;
    logic [4:0] mgmt_addr_i;
    logic [15:0] mgmt_wdata_i, pval, rdata, d;
    wire [15:0] mgmt_rdata_o, adv_word_o, pword;
    wire l10, l100, prx, flp_enable_o, tx_suppress_o, neg_complete_o;
    wire speed_100_o, full_duplex_o, link_ok_o;
    int err_count = 0;
    int num_checks = 0;
    int seed = 48066;
    int adv_m;
    int adv_q[$];
    anp_link_partner lp (.clk_i(clk_i), .want_10_i(w10), .want_100_i(w100),
        .page_go_i(pgo), .page_val_i(pval), .link_10_o(l10),
        .link_100_o(l100), .page_rx_o(prx), .page_word_o(pword));
    anp_autoneg #(.BREAK_CYC(20), .WAIT_CYC(15), .INHIBIT_CYC(16),
        .EXCHANGE_CYC(10)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .mgmt_addr_i(mgmt_addr_i), .mgmt_wr_i(mgmt_wr_i),
        .mgmt_wdata_i(mgmt_wdata_i), .mgmt_rd_i(mgmt_rd_i),
        .mgmt_rdata_o(mgmt_rdata_o), .link_10_i(l10), .link_100_i(l100),
        .page_rx_i(prx), .page_word_i(pword), .adv_word_o(adv_word_o),
        .flp_enable_o(flp_enable_o), .tx_suppress_o(tx_suppress_o),
        .neg_complete_o(neg_complete_o), .speed_100_o(speed_100_o),
        .full_duplex_o(full_duplex_o), .link_ok_o(link_ok_o));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Callers enter on a falling edge and leave on one
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        mgmt_addr_i <= a;
        mgmt_wdata_i <= v;
        mgmt_wr_i <= 1'b1;
        @(negedge clk_i);
        mgmt_wr_i <= 1'b0;
        @(negedge clk_i);
    endtask
    task automatic rd(input logic [4:0] a);
        mgmt_addr_i <= a;
        mgmt_rd_i <= 1'b1;
        @(negedge clk_i);
        mgmt_rd_i <= 1'b0;
        rdata = mgmt_rdata_o;
        @(negedge clk_i);
    endtask
    task automatic wait_on(input int w);
        int n;
        n = 0;
        while (!(w == 0 ? neg_complete_o === 1'b1 : w == 1 ?
            tx_suppress_o === 1'b1 : flp_enable_o === 1'b1)) begin
            @(negedge clk_i);
            n++;
            if (n > 600) begin
                err_count++;
                $display("MISMATCH t=%0t wait %h got=0 exp=1", $time, w);
                finish_test();
            end
        end
    endtask
    function automatic logic [15:0] st_m(input int c, input int l);
        return 16'h7849 | (c ? 16'h0020 : 16'h0000) | (l ? 16'h0004 : 16'h0000);
    endfunction
    initial begin
        rst_i = 1'b1;
        {mgmt_wr_i, mgmt_rd_i, w10, w100, pgo} = '0;
        mgmt_addr_i = 5'h00;
        mgmt_wdata_i = 16'h0000;
        pval = 16'h0000;
        adv_m = 16'h01E1;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        rst_i <= 1'b0;
        rd(5'h01); chk(rdata, st_m(0, 0));
        rd(5'h04); chk(rdata, adv_m[15:0]);
        rd(5'h02); chk(rdata, 16'h0000);
        wr(5'h01, 16'h0000); rd(5'h01); chk(rdata, st_m(0, 0));
        $display("test registers done");
        w10 <= 1'b1;
        wait_on(0);
        rd(5'h01); chk(rdata, st_m(1, 1));
        rd(5'h05); chk(rdata, 16'h0020);
        rd(5'h06); chk(rdata, 16'h0000);
        chk({speed_100_o, full_duplex_o}, 16'h0000);
        chk(link_ok_o, 16'h0001);
        w10 <= 1'b0;
        wait_on(1); chk(neg_complete_o, 16'h0000);
        chk(link_ok_o, 16'h0000);
        w100 <= 1'b1;
        wait_on(0);
        rd(5'h05); chk(rdata, 16'h0080);
        chk({speed_100_o, full_duplex_o}, 16'h0002);
        wr(5'h00, 16'h1200); chk(tx_suppress_o, 16'h0001);
        wait_on(0);
        $display("test parallel done");
        w100 <= 1'b0;
        wr(5'h04, 16'h0181); w10 <= 1'b1; wr(5'h00, 16'h1200);
        repeat (150) @(negedge clk_i);
        chk(neg_complete_o, 16'h0000);
        wr(5'h04, 16'h01E1); w100 <= 1'b1;
        repeat (60) @(negedge clk_i);
        rd(5'h06); chk(rdata & 16'h0010, 16'h0010);
        w10 <= 1'b0; w100 <= 1'b0;
        repeat (5) @(negedge clk_i);
        rd(5'h06); rd(5'h06); chk(rdata & 16'h0010, 16'h0000);
        $display("test detect faults done");
        for (int i = 0; i < 4; i++) begin
            d = 16'($random(seed));
            adv_q.push_back((d & 16'h21E0) | 16'h0001);
            wr(5'h04, d);
            rd(5'h04);
            adv_m = adv_q.pop_front();
            chk(rdata, adv_m[15:0]);
            chk(adv_word_o, adv_m[15:0]);
        end
        wr(5'h04, 16'h01E1);
        wr(5'h00, 16'h1200);
        wait_on(2);
        pval <= 16'hA1E0; pgo <= 1'b1;
        @(negedge clk_i);
        pgo <= 1'b0; w100 <= 1'b1;
        wait_on(0);
        chk({speed_100_o, full_duplex_o}, 16'h0003);
        rd(5'h01); chk(rdata, st_m(1, 1) | 16'h0010);
        rd(5'h05); chk(rdata, 16'hA1E0);
        rd(5'h06); chk(rdata, 16'h000B);
        $display("test negotiated done");
        wr(5'h00, 16'h2100);
        chk({flp_enable_o, tx_suppress_o, neg_complete_o}, 16'h0000);
        chk({speed_100_o, full_duplex_o}, 16'h0003);
        chk(link_ok_o, 16'h0001);
        wr(5'h00, 16'h1000); chk(tx_suppress_o, 16'h0001);
        $display("test forced done");
        wr(5'h04, 16'h0021);
        wr(5'h00, 16'h8000);
        chk(tx_suppress_o, 16'h0001);
        rd(5'h00);
        chk(rdata, 16'h3000);
        rd(5'h04);
        chk(rdata, 16'h01E1);
        rd(5'h05);
        chk(rdata, 16'h0000);
        rd(5'h01);
        chk(rdata, st_m(0, 0));
        $display("test soft reset done");
        finish_test();
    end
endmodule
bind anp_autoneg anp_autoneg_checker #(.BREAK_CYC(BREAK_CYC)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .mgmt_addr_i(mgmt_addr_i),
    .mgmt_wr_i(mgmt_wr_i), .mgmt_wdata_i(mgmt_wdata_i),
    .mgmt_rd_i(mgmt_rd_i), .mgmt_rdata_o(mgmt_rdata_o),
    .adv_word_o(adv_word_o), .flp_enable_o(flp_enable_o),
    .tx_suppress_o(tx_suppress_o), .neg_complete_o(neg_complete_o),
    .speed_100_o(speed_100_o), .full_duplex_o(full_duplex_o),
    .link_ok_o(link_ok_o));
